/* File: src/mca_thresh_map.svh */
// Bit map, addresses, reset values and sizes of the thresholding register
// Behaviour
// (R1) Zero pointer: no extra registers exist
// (R2) Extras contiguous at base plus pointer shl 3
// (R3) Bit 63 valid flag in every register
// (R4) Register zero holds pointer in 31:24
// (R5) Bit 62 reads one: counter present
// (R6) Lock set: writes to 60:0 dropped silently
// (R7) Lock writable only with write unlock set
// (R8) Bit 60 reports interrupt capability, read-only
// (R9) Bits 55:52 select vector entry, reset zero
// (R10) Software programs vector entry before enabling
// (R11) Count only while bit 51 set, reset zero
// (R12) Overflow rise: kind 01 raises interrupt
// (R13) Overflow set on step to maximum count
// (R14) Handler clears overflow when reloading counter
// (R15) Counter and overflow survive warm reset
// (R16) Unimplemented upper counter bits read zero
// (R17) Counter increments on logged errors, saturates
// (R18) Software preloads threshold minus wanted errors
// (R19) Pointer and present meaningful while valid
// (R20) Count only errors enabled for logging
// (R21) Interrupt only if capable, once per rise
`ifndef MCA_THRESH_MAP_SVH
`define MCA_THRESH_MAP_SVH

// ==========================================================================
// Addresses
`define MISC0_ADDR_DEF   32'h0000_0403
`define EXTRA_BASE       32'hc000_0400
`define EXTRA_SHIFT      3
`define EXTRA_MAX        8

// ==========================================================================
// Field positions
`define BIT_VALID        63
`define BIT_CNT_PRESENT  62
`define BIT_LOCK         61
`define BIT_IRQ_CAPABLE  60
`define LSB_VECTOR       52
`define BIT_CNT_ENABLE   51
`define LSB_KIND         49
`define BIT_OVERFLOW     48
`define LSB_TALLY        32
`define LSB_EXTRA_REGISTER_POINTER         24

// ==========================================================================
// Reset values and sizes
`define RST_LOCK         1'h0
`define RST_VECTOR       4'h0
`define RST_CNT_ENABLE   1'h0
`define RST_KIND         2'h0
`define RST_COLD_TALLY   16'h0000
`define TALLY_W_DEF      16
`define EXTRA_REGISTER_POINTER_DEF         8'h01
`define EXTRA_N_DEF      8
`define IRQ_CAPABLE_DEF  1'h1
`define KIND_NONE        2'h0
`define KIND_APIC        2'h1

`endif

/* File: src/mca_thresh_pkg.sv */
// Types shared by the thresholding register bank
package mca_thresh_pkg;

    // ======================================================================
    // Bus words
    typedef logic [31:0] msr_addr_t;
    typedef logic [63:0] msr_data_t;

    // ======================================================================
    // Whole state of the register bank
    typedef struct packed {
        logic              lock;
        logic [3:0]        vector;
        logic              cnt_enable;
        logic [1:0]        kind;
        logic              overflow;
        logic [15:0]       tally;
        logic [7:0][62:0]  extra;
        logic [63:0]       rdata;
        logic              irq;
    } misc_state_t;

endpackage : mca_thresh_pkg

/* File: src/error_tally_counter.sv */
// Saturating error tally next-value logic with threshold detection
`timescale 1ns/1ps

module error_tally_counter #(
    parameter int unsigned WIDTH = 16
) (
    // Current value and load
    input  wire logic [WIDTH-1:0] count_in,
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] load_value_in,
    // Counting event
    input  wire logic             step_in,
    // Results
    output logic      [WIDTH-1:0] next_count_out,
    output logic                  reached_max_out
);

    localparam logic [WIDTH-1:0] MAX_COUNT = '1;

    logic [WIDTH-1:0] base;

    // A software load is applied first so a same-cycle error is not lost
    always_comb begin
        base            = load_in ? load_value_in : count_in;
        reached_max_out = 1'b0;
        next_count_out  = base;
        if (step_in && base != MAX_COUNT) begin      // R17
            next_count_out  = base + 1'b1;
            reached_max_out = (base == MAX_COUNT - 1'b1); // R13
        end
    end

endmodule : error_tally_counter

/* File: src/error_threshold_misc.sv */
// Thresholding miscellaneous register with extra register block
`timescale 1ns/1ps
`include "mca_thresh_map.svh"

module error_threshold_misc #(
    parameter int unsigned TALLY_W       = `TALLY_W_DEF,
    parameter logic [7:0]  BLOCK_POINTER = `EXTRA_REGISTER_POINTER_DEF,
    parameter int unsigned EXTRA_N       = `EXTRA_N_DEF,
    parameter logic        IRQ_CAPABLE   = `IRQ_CAPABLE_DEF,
    parameter logic [31:0] MISC0_ADDR    = `MISC0_ADDR_DEF
) (
    // Clock and resets
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    input  wire logic                      warm_reset_in,
    // Register port
    input  wire mca_thresh_pkg::msr_addr_t addr_in,
    input  wire mca_thresh_pkg::msr_data_t wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output mca_thresh_pkg::msr_data_t      rdata_out,
    // Error logging path
    input  wire logic                      error_logged_in,
    input  wire logic                      source_log_enable_in,
    // Hardware configuration
    input  wire logic                      status_write_unlock_in,
    // Interrupt delivery
    output logic                           apic_irq_req_out,
    output logic [3:0]                     apic_vector_entry_select_out
);
    import mca_thresh_pkg::*;

    // ======================================================================
    // Geometry
    // A zero pointer removes the extra block entirely
    localparam int unsigned EXTRA_USED =
        (BLOCK_POINTER == 8'h00) ? 0 :
        (EXTRA_N > `EXTRA_MAX) ? `EXTRA_MAX : EXTRA_N;         // R1
    localparam logic [31:0] EXTRA_FIRST =
        `EXTRA_BASE + {21'h0, BLOCK_POINTER, 3'h0};            // R2
    localparam logic [TALLY_W-1:0] TALLY_MAX = '1;

    // ======================================================================
    // Address decode, used by both read and write paths
    function automatic logic extra_hit(input msr_addr_t a);
        logic [31:0] off;
        off = a - EXTRA_FIRST;
        return (EXTRA_USED != 0) && (a >= EXTRA_FIRST) &&
               (off < EXTRA_USED);                              // R2
    endfunction : extra_hit

    function automatic logic [2:0] extra_index(input msr_addr_t a);
        logic [31:0] off;
        off = a - EXTRA_FIRST;
        return off[2:0];
    endfunction : extra_index

    // ======================================================================
    // State
    misc_state_t s;
    misc_state_t next_s;

    logic               hit0_wr;
    logic               hit0_rd;
    logic               count_step;
    logic               tally_load;
    logic [TALLY_W-1:0] tally_next;
    logic               tally_at_max;
    msr_data_t          misc0_view;

    assign hit0_wr = wr_in && (addr_in == MISC0_ADDR);
    assign hit0_rd = rd_in && (addr_in == MISC0_ADDR);

    // Counting stops during warm reset so the kept value stays coherent
    assign count_step = error_logged_in && source_log_enable_in &&  // R20
                        s.cnt_enable && !warm_reset_in;            // R11

    // Locked register drops the load without any fault
    assign tally_load = hit0_wr && !s.lock;                        // R6

    error_tally_counter #(
        .WIDTH           (TALLY_W)
    ) u_tally (
        .count_in        (s.tally[TALLY_W-1:0]),
        .load_in         (tally_load),
        .load_value_in   (wdata_in[`LSB_TALLY +: TALLY_W]),
        .step_in         (count_step),
        .next_count_out  (tally_next),
        .reached_max_out (tally_at_max)
    );

    // ======================================================================
    // Read view of register zero
    always_comb begin
        misc0_view                      = '0;
        misc0_view[`BIT_VALID]          = 1'b1;                    // R3 R19
        misc0_view[`BIT_CNT_PRESENT]    = 1'b1;                    // R5
        misc0_view[`BIT_LOCK]           = s.lock;
        misc0_view[`BIT_IRQ_CAPABLE]    = IRQ_CAPABLE;             // R8
        misc0_view[`LSB_VECTOR +: 4]    = s.vector;
        misc0_view[`BIT_CNT_ENABLE]     = s.cnt_enable;
        misc0_view[`LSB_KIND +: 2]      = s.kind;
        misc0_view[`BIT_OVERFLOW]       = s.overflow;
        misc0_view[`LSB_TALLY +: TALLY_W] = s.tally[TALLY_W-1:0]; // R16
        misc0_view[`LSB_EXTRA_REGISTER_POINTER +: 8]      = BLOCK_POINTER;           // R4
    end

    // ======================================================================
    // Next state
    always_comb begin
        next_s = s;

        // Control fields under the lock
        if (hit0_wr && !s.lock) begin                              // R6
            next_s.vector     = wdata_in[`LSB_VECTOR +: 4];        // R9
            next_s.cnt_enable = wdata_in[`BIT_CNT_ENABLE];
            next_s.kind       = wdata_in[`LSB_KIND +: 2];
            next_s.overflow   = wdata_in[`BIT_OVERFLOW];           // R14
        end

        // Lock bit follows the hardware configuration gate only
        if (hit0_wr && status_write_unlock_in) begin
            next_s.lock = wdata_in[`BIT_LOCK];                     // R7
        end

        // Counter; unused upper bits are held at zero
        next_s.tally = '0;
        next_s.tally[TALLY_W-1:0] = tally_next;                    // R16

        // Hardware set wins over a same-cycle software clear
        if (tally_at_max) begin
            next_s.overflow = 1'b1;                                // R13
        end

        // Extra registers: plain storage behind the valid flag
        if (wr_in && extra_hit(addr_in)) begin
            next_s.extra[extra_index(addr_in)] = wdata_in[62:0];
        end

        // Rising overflow asks for an interrupt exactly once
        next_s.irq = !s.overflow && next_s.overflow &&
                     (s.kind == `KIND_APIC) && IRQ_CAPABLE;        // R12 R21

        // Read data stand for the one cycle after the strobe
        next_s.rdata = '0;
        if (hit0_rd) begin
            next_s.rdata = misc0_view;
        end else if (rd_in && extra_hit(addr_in)) begin
            next_s.rdata = {1'b1, s.extra[extra_index(addr_in)]};  // R3
        end

        // Warm reset restores control but keeps the tally and flag
        if (warm_reset_in) begin                                   // R15
            next_s.lock       = `RST_LOCK;
            next_s.vector     = `RST_VECTOR;
            next_s.cnt_enable = `RST_CNT_ENABLE;
            next_s.kind       = `RST_KIND;
            next_s.tally      = s.tally;
            next_s.overflow   = s.overflow;
            next_s.rdata      = '0;
            next_s.irq        = 1'b0;
        end
    end

    // ======================================================================
    // State register; cold values of tally and flag are free, zero chosen
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s            <= '0;
            s.lock       <= `RST_LOCK;
            s.vector     <= `RST_VECTOR;
            s.cnt_enable <= `RST_CNT_ENABLE;
            s.kind       <= `RST_KIND;
            s.tally      <= `RST_COLD_TALLY;
        end else begin
            s <= next_s;
        end
    end

    // ======================================================================
    // Outputs
    assign rdata_out                    = s.rdata;
    assign apic_irq_req_out             = s.irq;
    assign apic_vector_entry_select_out = s.vector;                // R9

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in || warm_reset_in);

    sequence seq_wr0;
        wr_in && addr_in == MISC0_ADDR;
    endsequence

    sequence seq_rd0;
        rd_in && addr_in == MISC0_ADDR;
    endsequence

    sequence seq_quiet;
        !wr_in ##1 !wr_in;
    endsequence

    sequence seq_step_to_max;
        count_step && !wr_in && s.tally[TALLY_W-1:0] == TALLY_MAX - 1'b1;
    endsequence

    AST_RD_VALID: assert property (seq_rd0 |=> rdata_out[63:62] == 2'h3) // R3
        else $error("register zero lost valid or present flag");

    AST_RD_PTR: assert property ( // R4
        seq_rd0 |=> rdata_out[31:24] == BLOCK_POINTER &&
                    rdata_out[23:0] == 24'h0)
        else $error("block pointer field wrong on read");

    AST_RD_CAP: assert property ( // R8
        seq_rd0 |=> rdata_out[60] == IRQ_CAPABLE && rdata_out[59:56] == 4'h0)
        else $error("capability bit wrong on read");

    AST_LOCK_DROP: assert property ( // R6
        seq_wr0 and (s.lock && !status_write_unlock_in) |=>
            $stable(s.vector) && $stable(s.kind) && $stable(s.cnt_enable))
        else $error("write took effect while locked");

    AST_LOCK_GATE: assert property ( // R7
        seq_wr0 and !status_write_unlock_in |=> $stable(s.lock))
        else $error("lock changed without write unlock");

    AST_NO_COUNT: assert property ( // R11
        !wr_in && (!s.cnt_enable || !source_log_enable_in) |=>
            $stable(s.tally))
        else $error("tally moved while counting disabled");

    AST_STEP: assert property ( // R17
        !wr_in && count_step && s.tally[TALLY_W-1:0] != TALLY_MAX |=>
            s.tally[TALLY_W-1:0] == $past(s.tally[TALLY_W-1:0]) + 1'b1)
        else $error("tally missed an increment");

    AST_SATURATE: assert property ( // R17
        s.tally[TALLY_W-1:0] == TALLY_MAX ##0 seq_quiet |->
            s.tally[TALLY_W-1:0] == TALLY_MAX)
        else $error("tally wrapped past its maximum");

    AST_OF_SET: assert property ( // R13
        seq_step_to_max |=> s.overflow && s.tally[TALLY_W-1:0] == TALLY_MAX)
        else $error("overflow not set at threshold");

    AST_IRQ_CAUSE: assert property ( // R12
        apic_irq_req_out |-> s.overflow && !$past(s.overflow) &&
                             $past(s.kind) == `KIND_APIC)
        else $error("interrupt without overflow rise and apic kind");

    AST_IRQ_ONCE: assert property ( // R21
        apic_irq_req_out |=> !apic_irq_req_out)
        else $error("interrupt repeated for one rise");

    AST_IRQ_FIRE: assert property ( // R12
        seq_step_to_max and (!s.overflow && s.kind == `KIND_APIC) |=>
            apic_irq_req_out == IRQ_CAPABLE)
        else $error("interrupt missing on overflow rise");

    AST_NO_EXTRA: assert property ( // R1
        rd_in && addr_in == EXTRA_FIRST |=>
            rdata_out[63] == (EXTRA_USED != 0))
        else $error("extra register presence wrong");

    AST_ZERO_TOP: assert property ( // R16
        seq_rd0 |=> rdata_out[47:32] ==
                    16'($past(s.tally[TALLY_W-1:0])))
        else $error("upper tally bits not zero");

endmodule : error_threshold_misc

/* File: tb/err_log_model.sv */
// Error logging path and interrupt sink facing the threshold register
`timescale 1ns/1ps

module err_log_model (
    // Clock
    input  wire logic clk_in,
    // Error path toward the register
    output logic      error_logged_out,
    output logic      source_enable_out,
    // Interrupt delivery from the register
    input  wire logic irq_in
);
    int irq_count = 0;

    // ======================================================================
    // Quiet path at time zero
    initial begin
        error_logged_out  = 1'b0;
        source_enable_out = 1'b0;
    end

    // One pulse per logged error, gating level held across it
    task automatic log_error(input logic src_en);
        @(posedge clk_in);
        error_logged_out  <= 1'b1;
        source_enable_out <= src_en;
        @(posedge clk_in);
        error_logged_out  <= 1'b0;
    endtask : log_error

    // Requests are one-cycle pulses, so every high cycle is one request
    always @(posedge clk_in) begin
        if (irq_in === 1'b1) irq_count++;
    end
endmodule : err_log_model

/* File: tb/mca_error_threshold_counter_tb.sv */
// Self-checking bench for the thresholding register bank
`timescale 1ns/1ps

module mca_error_threshold_counter_tb;
    import mca_thresh_pkg::*;

    logic      clk_in = 1'b0;
    logic      reset_in = 1'b1;
    logic      warm = 1'b0;
    msr_addr_t addr = '0;
    msr_data_t wdata = '0;
    logic      wr_s = 1'b0;
    logic      rd_s = 1'b0;
    logic      unlock = 1'b0;
    msr_data_t rdata;
    logic      err_ev;
    logic      src_en;
    logic      irq;
    logic [3:0] vec;
    msr_data_t exp_q[$];
    logic      rd_seen = 1'b0;
    int        fail_count = 0;
    int        compares = 0;
    int        cycles = 0;
    int        seed = 48;
    int        n0;
    logic      rb;
    msr_data_t d;

    // ======================================================================
    // Design and partner
    error_threshold_misc DUT (
        .clk_in(clk_in), .reset_in(reset_in), .warm_reset_in(warm),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
        .rdata_out(rdata), .error_logged_in(err_ev),
        .source_log_enable_in(src_en), .status_write_unlock_in(unlock),
        .apic_irq_req_out(irq), .apic_vector_entry_select_out(vec));

    err_log_model src (.clk_in(clk_in), .error_logged_out(err_ev),
        .source_enable_out(src_en), .irq_in(irq));

    // 100 ns period
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // ======================================================================
    // Comparison and closing
    task automatic check(input string name, input msr_data_t seen,
                         input msr_data_t exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // Expected register zero image; pointer 01 and capable bit by default
    function automatic msr_data_t r0(logic lk, logic [3:0] v, logic en,
                                     logic [1:0] k, logic of, logic [15:0] t);
        return {2'b11, lk, 1'b1, 4'h0, v, en, k, of, t, 8'h01, 24'h0};
    endfunction : r0

    // ======================================================================
    // Bus cycles: strobe for one cycle, read noted for the monitor
    task automatic wr(input msr_addr_t a, input msr_data_t dv);
        @(posedge clk_in);
        addr  <= a;
        wdata <= dv;
        wr_s  <= 1'b1;
        @(posedge clk_in);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd(input msr_addr_t a, input msr_data_t exp);
        @(posedge clk_in);
        exp_q.push_back(exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
    endtask : rd

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_in) begin
        if (rd_seen) check("rdata", rdata, exp_q.pop_front());
        rd_seen <= rd_s;
    end

    // Hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(32'h0000_0403, r0(0, 4'h0, 0, 2'h0, 0, 16'h0000));
        rd(32'h0000_0404, '0);
        rd(32'hc000_0410, '0);
        // Extra block: plain storage, valid bit always one
        for (int k = 0; k < 8; k++) begin
            d = {$random(seed), $random(seed)};
            wr(32'hc000_0408 + k, d);
            rd(32'hc000_0408 + k, {1'b1, d[62:0]});
        end
        // Counting disabled, then source not enabled for logging
        wr(32'h0000_0403, r0(0, 4'h3, 0, 2'h1, 0, 16'h0010));
        src.log_error(1'b1);
        rd(32'h0000_0403, r0(0, 4'h3, 0, 2'h1, 0, 16'h0010));
        check("vector", {60'h0, vec}, 64'h3);
        wr(32'h0000_0403, r0(0, 4'h3, 1, 2'h1, 0, 16'h0010));
        src.log_error(1'b0);
        src.log_error(1'b1);
        rd(32'h0000_0403, r0(0, 4'h3, 1, 2'h1, 0, 16'h0011));
        // Every interrupt kind: step to maximum, then once more at max
        for (int k = 0; k < 4; k++) begin
            n0 = src.irq_count;
            wr(32'h0000_0403, r0(0, k[3:0], 1, k[1:0], 0, 16'hfffe));
            src.log_error(1'b1);
            src.log_error(1'b1);
            rd(32'h0000_0403, r0(0, k[3:0], 1, k[1:0], 1, 16'hffff));
            check("irq", 64'(src.irq_count - n0), 64'(k == 1));
        end
        // Warm reset keeps tally and overflow, clears the controls
        @(posedge clk_in);
        warm <= 1'b1;
        repeat (2) @(posedge clk_in);
        warm <= 1'b0;
        rd(32'h0000_0403, r0(0, 4'h0, 0, 2'h0, 1, 16'hffff));
        check("vector", {60'h0, vec}, 64'h0);
        // Handler reload clears overflow without an interrupt
        n0 = src.irq_count;
        wr(32'h0000_0403, r0(0, 4'h1, 1, 2'h1, 0, 16'hfffd));
        rd(32'h0000_0403, r0(0, 4'h1, 1, 2'h1, 0, 16'hfffd));
        check("irq", 64'(src.irq_count - n0), 64'h0);
        // Lock set while unlocked; later writes dropped, counting goes on
        @(posedge clk_in);
        unlock <= 1'b1;
        wr(32'h0000_0403, r0(1, 4'h2, 1, 2'h0, 0, 16'h0005));
        @(posedge clk_in);
        unlock <= 1'b0;
        wr(32'h0000_0403, r0(0, 4'h9, 0, 2'h1, 1, 16'h1234));
        src.log_error(1'b1);
        rd(32'h0000_0403, r0(1, 4'h2, 1, 2'h0, 0, 16'h0006));
        @(posedge clk_in);
        unlock <= 1'b1;
        wr(32'h0000_0403, r0(0, 4'h0, 0, 2'h0, 0, 16'h0000));
        // Unlocking write still meets the old lock: only the lock moves
        rd(32'h0000_0403, r0(0, 4'h2, 1, 2'h0, 0, 16'h0006));
        // Random unlock level decides whether the lock takes
        rb = 1'($random(seed));
        @(posedge clk_in);
        unlock <= rb;
        wr(32'h0000_0403, r0(1, 4'h2, 1, 2'h0, 0, 16'h0006));
        src.log_error(rb);
        rd(32'h0000_0403,
           r0(rb, 4'h2, 1, 2'h0, 0, 16'h0006 + 16'(rb)));
        repeat (3) @(posedge clk_in);
        wrap_up();
    end
endmodule : mca_error_threshold_counter_tb
